/* src/ssd_pin_sync.sv */
`timescale 1ns/100ps
module ssd_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_b_i,
    // pins and synchronised view
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } ssd_sync_type;

    ssd_sync_type st_reg;
    ssd_sync_type st_next;

    if (W < 1)
    begin : g_width_check
        $error("ssd_pin_sync needs at least one pin");
    end

    always_comb
    begin
        st_next      = st_reg;
        st_next.meta = pin_i;
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            st_reg <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.sync;
    assign rise_o  = st_reg.sync & ~st_reg.prev;
    assign fall_o  = ~st_reg.sync & st_reg.prev;

endmodule // ssd_pin_sync

/* src/ssd_pkg.sv */
package ssd_pkg;

    // ------------------------------------------------------------
    // register indexes on the plain register port
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_STAT  = 2'h1;
    localparam logic [1:0] ADDR_UPPER = 2'h2;
    localparam logic [1:0] ADDR_LOWER = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h80;

    // ------------------------------------------------------------
    // serial_control_reg fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_EXT_BIT = 3;
    localparam int CTRL_CKS_HI  = 2;

    // ------------------------------------------------------------
    // serial_control_status fields
    // ------------------------------------------------------------
    localparam int STAT_ONE_BIT = 7;
    localparam int STAT_LVL_BIT = 6;
    localparam int STAT_OVR_BIT = 5;
    localparam int STAT_GO_BIT  = 0;

    // ------------------------------------------------------------
    // modes and widths
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_8    = 2'h0;
    localparam logic [1:0] MODE_16   = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [4:0] BITS_8    = 5'h08;
    localparam logic [4:0] BITS_16   = 5'h10;

    // ------------------------------------------------------------
    // prescaler ratios in system clocks, indexed by clock select
    // ------------------------------------------------------------
    localparam logic [7:0][10:0] DIV_RATIO = {
        11'h002, 11'h004, 11'h008, 11'h010,
        11'h020, 11'h040, 11'h100, 11'h400
    };

    typedef enum logic [0:0] {
        XS_IDLE = 1'b0,
        XS_RUN  = 1'b1
    } ssd_xfer_type;

endpackage

/* src/ssd_serial_unit.sv */
// Operation
// [RULE1] status resets to 80h, top bit one
// [RULE2] status bits four to two read zero
// [RULE3] level bit drives and reads output pin
// [RULE4] output keeps last sent bit afterwards
// [RULE5] level bit overridden once transfer starts
// [RULE6] software avoids status writes during transfer
// [RULE7] external clock pulse when idle sets overrun
// [RULE8] overrun cleared by zero after read
// [RULE9] software writes zero to bit one
// [RULE10] writing one to go flag starts transfer
// [RULE11] go flag reads busy until completion
// [RULE12] 8-bit: lower byte shifts LSB first
// [RULE13] 16-bit: upper byte feeds lower byte
// [RULE14] 16-bit: input enters via upper byte
// [RULE15] software touches data only when idle
// [RULE16] data bytes are not reset
// [RULE17] mode field selects 8, 16, continuous
// [RULE18] send on falling, sample on rising
// [RULE19] control write aborts and reinitialises unit
// [RULE20] completion raises maskable done request
// [RULE21] internal clock gives exactly 8/16 pulses
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module ssd_serial_unit #(
    parameter int HALF_W = 9
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    // register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // serial pins
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe_o,
    input  wire logic       serial_in_pin_i,
    output logic            serial_out_pin_o,
    // completion request
    input  wire logic       transfer_done_clear_i,
    input  wire logic       transfer_done_enable_i,
    output logic            transfer_done_request_o,
    output logic            transfer_done_irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           ctrl;
        logic                 lvl;
        logic                 ovr;
        logic                 ovr_seen;
        ssd_pkg::ssd_xfer_type xs;
        logic [7:0]           upper;
        logic [7:0]           lower;
        logic [4:0]           bit_cnt;
        logic [HALF_W-1:0]    div_cnt;
        logic                 sck;
        logic                 done;
        logic [7:0]           rdata;
    } ssd_state_type;

    ssd_state_type st_reg;
    ssd_state_type st_next;

    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    if (HALF_W < 9)
    begin : g_half_w_check
        $error("divider counter too narrow for the slowest ratio");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [1:0] addr, input logic [1:0] idx);
        return addr == idx;
    endfunction

    function automatic logic [HALF_W-1:0] half_last(input logic [2:0] cks);
        logic [10:0] r;
        r = ssd_pkg::DIV_RATIO[cks];
        return HALF_W'((r >> 1) - 11'h001);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers: [0] serial clock, [1] serial input
    // ------------------------------------------------------------
    ssd_pin_sync #(
        .W (2)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .pin_i     ({serial_in_pin_i, serial_clock_pin_i}),
        .level_o   (pin_level),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic       ext_clk;
    logic       fall_ev;
    logic       rise_ev;
    logic       run;
    logic [4:0] width;

    assign mode    = st_reg.ctrl[ssd_pkg::CTRL_MODE_HI:ssd_pkg::CTRL_MODE_LO];
    assign ext_clk = st_reg.ctrl[ssd_pkg::CTRL_EXT_BIT];
    assign run     = st_reg.xs == ssd_pkg::XS_RUN;
    // [RULE17] width by mode
    assign width   = (mode == ssd_pkg::MODE_16) ? ssd_pkg::BITS_16 : ssd_pkg::BITS_8;

    always_comb
    begin
        logic tick;
        logic [7:0] stat_rd;
        tick     = 1'b0;
        stat_rd  = 8'h00;
        fall_ev  = 1'b0;
        rise_ev  = 1'b0;
        st_next  = st_reg;
        st_next.rdata = 8'h00;

        // internal serial clock generator
        if (!ext_clk && (run || mode == ssd_pkg::MODE_CONT))
        begin
            if (st_reg.div_cnt == half_last(st_reg.ctrl[ssd_pkg::CTRL_CKS_HI:0]))
            begin
                tick = 1'b1;
                st_next.div_cnt = '0;
            end
            else
            begin
                st_next.div_cnt = st_reg.div_cnt + 1'b1;
            end
        end
        if (tick)
        begin
            st_next.sck = ~st_reg.sck;
        end

        // [RULE18] edge selection
        if (ext_clk)
        begin
            fall_ev = run && pin_fall[0];
            rise_ev = run && pin_rise[0];
        end
        else
        begin
            fall_ev = run && tick && st_reg.sck;
            rise_ev = run && tick && !st_reg.sck;
        end

        // [RULE5] shifted data takes over the pin
        if (fall_ev)
        begin
            st_next.lvl = st_reg.lower[0];
        end

        // [RULE12] shift chain on rising edge
        if (rise_ev)
        begin
            // [RULE13] upper feeds lower
            if (mode == ssd_pkg::MODE_16)
            begin
                st_next.lower = {st_reg.upper[0], st_reg.lower[7:1]};
                // [RULE14] input enters upper
                st_next.upper = {pin_level[1], st_reg.upper[7:1]};
            end
            else
            begin
                st_next.lower = {pin_level[1], st_reg.lower[7:1]};
            end
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            // [RULE21] stop after width pulses
            if (st_reg.bit_cnt + 5'h01 == width)
            begin
                st_next.xs = ssd_pkg::XS_IDLE;
                st_next.sck = 1'b1;
                st_next.div_cnt = '0;
                // [RULE20] completion request
                st_next.done = 1'b1;
            end
        end

        // [RULE2] fixed status bits
        // [RULE11] go reads busy
        stat_rd = {1'b1, st_reg.lvl, st_reg.ovr, 3'h0, 1'b0, run};
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ssd_pkg::ADDR_CTRL:  st_next.rdata = st_reg.ctrl;
                ssd_pkg::ADDR_STAT:  st_next.rdata = stat_rd;
                ssd_pkg::ADDR_UPPER: st_next.rdata = st_reg.upper;
                ssd_pkg::ADDR_LOWER: st_next.rdata = st_reg.lower;
                default:             st_next.rdata = 8'h00;
            endcase
            if (hit(reg_addr_i, ssd_pkg::ADDR_STAT) && st_reg.ovr)
            begin
                st_next.ovr_seen = 1'b1;
            end
        end

        // register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ssd_pkg::ADDR_CTRL:
                begin
                    // [RULE19] abort and reinitialise
                    st_next.ctrl    = reg_wdata_i;
                    st_next.xs      = ssd_pkg::XS_IDLE;
                    st_next.bit_cnt = 5'h00;
                    st_next.div_cnt = '0;
                    st_next.sck     = 1'b1;
                end
                ssd_pkg::ADDR_STAT:
                begin
                    // [RULE3] level bit drives pin
                    st_next.lvl = reg_wdata_i[ssd_pkg::STAT_LVL_BIT];
                    // [RULE8] clear only after seen
                    if (!reg_wdata_i[ssd_pkg::STAT_OVR_BIT] && st_reg.ovr_seen)
                    begin
                        st_next.ovr      = 1'b0;
                        st_next.ovr_seen = 1'b0;
                    end
                    // [RULE10] start on one
                    if (reg_wdata_i[ssd_pkg::STAT_GO_BIT] && !run
                        && mode != ssd_pkg::MODE_CONT)
                    begin
                        st_next.xs      = ssd_pkg::XS_RUN;
                        st_next.bit_cnt = 5'h00;
                        st_next.div_cnt = '0;
                        st_next.sck     = 1'b1;
                    end
                end
                ssd_pkg::ADDR_UPPER: st_next.upper = reg_wdata_i;
                ssd_pkg::ADDR_LOWER: st_next.lower = reg_wdata_i;
                default:             st_next.ctrl  = st_reg.ctrl;
            endcase
        end

        // [RULE7] stray external pulse when idle; set beats clear
        if (ext_clk && !run && mode != ssd_pkg::MODE_CONT && pin_fall[0])
        begin
            st_next.ovr = 1'b1;
        end

        // done request: set beats clear
        if (transfer_done_clear_i && !st_next.done)
        begin
            st_next.done = 1'b0;
        end
        else if (transfer_done_clear_i && !(rise_ev && st_reg.bit_cnt + 5'h01 == width))
        begin
            st_next.done = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            // [RULE1] status reset value
            st_reg.ctrl     <= ssd_pkg::CTRL_RESET;
            st_reg.lvl      <= ssd_pkg::STAT_RESET[ssd_pkg::STAT_LVL_BIT];
            st_reg.ovr      <= ssd_pkg::STAT_RESET[ssd_pkg::STAT_OVR_BIT];
            st_reg.ovr_seen <= 1'b0;
            st_reg.xs       <= ssd_pkg::XS_IDLE;
            st_reg.bit_cnt  <= 5'h00;
            st_reg.div_cnt  <= '0;
            st_reg.sck      <= 1'b1;
            st_reg.done     <= 1'b0;
            st_reg.rdata    <= 8'h00;
            // [RULE16] data bytes keep no reset
            st_reg.upper    <= st_next.upper;
            st_reg.lower    <= st_next.lower;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o             = st_reg.rdata;
    // [RULE4] level holds last bit
    assign serial_out_pin_o        = st_reg.lvl;
    assign serial_clock_pin_o      = st_reg.sck;
    assign serial_clock_pin_oe_o   = ~ext_clk;
    assign transfer_done_request_o = st_reg.done;
    assign transfer_done_irq_o     = st_reg.done & transfer_done_enable_i;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_status_fixed_bits : assert property ( // [RULE2]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        reg_rd_i && reg_addr_i == ssd_pkg::ADDR_STAT
        |=> reg_rdata_o[7] == 1'b1 && reg_rdata_o[4:1] == 4'h0
            && reg_rdata_o[6] == $past(serial_out_pin_o))
        else $error("status fixed bits or level wrong");

    a_level_write : assert property ( // [RULE3]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        reg_wr_i && reg_addr_i == ssd_pkg::ADDR_STAT && !run
        |=> serial_out_pin_o == $past(reg_wdata_i[6]))
        else $error("level bit did not reach pin");

    a_go_starts : assert property ( // [RULE10]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        reg_wr_i && reg_addr_i == ssd_pkg::ADDR_STAT && reg_wdata_i[0] && !run
        && mode != ssd_pkg::MODE_CONT |=> run)
        else $error("start write did not start transfer");

    a_ctrl_abort : assert property ( // [RULE19]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        reg_wr_i && reg_addr_i == ssd_pkg::ADDR_CTRL |=> !run && st_reg.bit_cnt == 5'h00)
        else $error("control write did not abort");

    a_overrun_set : assert property ( // [RULE7]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ext_clk && !run && mode != ssd_pkg::MODE_CONT && pin_fall[0] |=> st_reg.ovr)
        else $error("overrun not flagged");

    a_overrun_one_write : assert property ( // [RULE8]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        st_reg.ovr && !(reg_wr_i && reg_addr_i == ssd_pkg::ADDR_STAT
        && !reg_wdata_i[5] && st_reg.ovr_seen) |=> st_reg.ovr)
        else $error("overrun cleared without proper write");

    a_busy_end_done : assert property ( // [RULE11]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        run ##1 !run && !$past(reg_wr_i && reg_addr_i == ssd_pkg::ADDR_CTRL)
        |-> transfer_done_request_o && $past(st_reg.bit_cnt) == width - 5'h01)
        else $error("busy ended without completion");

    a_pulse_bound : assert property ( // [RULE21]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        run |-> st_reg.bit_cnt < width)
        else $error("too many serial clock pulses");

    a_sample_input : assert property ( // [RULE14]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rise_ev && mode == ssd_pkg::MODE_16 && !reg_wr_i
        |=> st_reg.upper[7] == $past(pin_level[1]) && st_reg.lower[7] == $past(st_reg.upper[0]))
        else $error("16-bit chain shifted wrongly");

    a_send_on_fall : assert property ( // [RULE18]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        fall_ev && !reg_wr_i |=> serial_out_pin_o == $past(st_reg.lower[0]))
        else $error("transmit bit not driven on falling edge");

endmodule // ssd_serial_unit

/* test/ssd_peer_model.sv */
`timescale 1ns/100ps
module ssd_peer_model (
    // link pins seen from the far side
    input  wire logic        link_clk_i,
    input  wire logic        so_i,
    output logic             si_o,
    // frame set-up and result
    input  wire logic        load_i,
    input  wire logic [15:0] tx_word_i,
    input  wire logic [4:0]  nbits_i,
    output logic      [15:0] rx_word_o,
    output logic      [4:0]  rises_o
);
    logic [4:0] sent;

    initial
    begin
        si_o      = 1'b0;
        sent      = 5'h00;
        rx_word_o = 16'h0000;
        rises_o   = 5'h00;
    end

    always @(posedge load_i)
    begin
        sent      = 5'h00;
        rx_word_o = 16'h0000;
        rises_o   = 5'h00;
    end

    // send on falling edge
    // outside the frame the line toggles so stale data is never seen
    always @(negedge link_clk_i)
    begin
        if (sent < nbits_i)
        begin
            si_o <= tx_word_i[sent[3:0]];
            sent <= sent + 5'h01;
        end
        else
        begin
            si_o <= ~si_o;
        end
    end

    always @(posedge link_clk_i)
    begin
        rx_word_o <= {so_i, rx_word_o[15:1]};
        rises_o   <= rises_o + 5'h01;
    end
endmodule // ssd_peer_model

/* test/ssd_serial_unit_test.sv */
`timescale 1ns/100ps
module ssd_serial_unit_test;
    logic        clk_sys_i, rst_b_i, reg_wr, reg_rd, sck_o, sck_oe, ext_sck, si, so;
    logic        done_clr, done_en, done_req, done_irq, peer_load, link_clk;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, s;
    logic [15:0] peer_tx, peer_rx;
    logic [4:0]  peer_nb, peer_rises;
    int          bad_count, comparisons;
    logic [1:0]  md_tab [3] = '{ssd_pkg::MODE_8, ssd_pkg::MODE_16, ssd_pkg::MODE_8};
    logic [15:0] tx_tab [3] = '{16'h00a5, 16'h165a, 16'h0033};
    logic [15:0] pw_tab [3] = '{16'h003c, 16'hc3e1, 16'h00c6};

    assign link_clk = sck_oe ? sck_o : ext_sck;

    ssd_serial_unit dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .serial_clock_pin_i(link_clk), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .serial_in_pin_i(si), .serial_out_pin_o(so),
        .transfer_done_clear_i(done_clr), .transfer_done_enable_i(done_en),
        .transfer_done_request_o(done_req), .transfer_done_irq_o(done_irq));

    ssd_peer_model peer_u (.link_clk_i(link_clk), .so_i(so), .si_o(si), .load_i(peer_load),
        .tx_word_i(peer_tx), .nbits_i(peer_nb), .rx_word_o(peer_rx), .rises_o(peer_rises));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    begin
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    end
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    begin
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rdata;
    end
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
    begin
        chk_val(what, {15'h0000, exp}, {15'h0000, got});
    end
    endtask

    task automatic finish_test();
    begin
        $display("counts: %0d compared, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    task automatic wait_idle(input int lim);
        logic [7:0] st;
        int         n;
    begin
        n  = 0;
        st = 8'h01;
        while (st[0] !== 1'b0 && n < lim)
        begin
            rd_reg(ssd_pkg::ADDR_STAT, st);
            n++;
        end
        if (st[0] !== 1'b0)
        begin
            bad_count++;
            $display("BAD busy expected 0 seen %b", st[0]);
            finish_test();
        end
    end
    endtask

    task automatic load_peer(input logic [15:0] w, input logic [4:0] n);
    begin
        @(posedge clk_sys_i);
        peer_tx   <= w;
        peer_nb   <= n;
        peer_load <= 1'b1;
        @(posedge clk_sys_i);
        peer_load <= 1'b0;
    end
    endtask

    task automatic ext_pulses(input int n);
    begin
        repeat (n)
        begin
            repeat (4) @(posedge clk_sys_i);
            ext_sck <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            ext_sck <= 1'b1;
        end
        repeat (4) @(posedge clk_sys_i);
    end
    endtask

    // one internally clocked frame, ratio 16
    task automatic run_int(input logic [1:0] md, input logic [15:0] txd, input logic [15:0] pw);
        logic [7:0] r;
        int         nb;
    begin
        nb = (md == ssd_pkg::MODE_16) ? 16 : 8;
        wr_reg(ssd_pkg::ADDR_CTRL, {md, 6'h04});
        wr_reg(ssd_pkg::ADDR_UPPER, txd[15:8]);
        wr_reg(ssd_pkg::ADDR_LOWER, txd[7:0]);
        load_peer(pw, nb[4:0]);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h41);
        rd_reg(ssd_pkg::ADDR_STAT, r);
        chk_bit("go flag", 1'b1, r[0]);
        chk_bit("sck oe", 1'b1, sck_oe);
        wait_idle(1000);
        chk_val("peer rx", txd & (16'hffff >> (16 - nb)), peer_rx >> (16 - nb));
        chk_val("sck rises", nb[15:0], {11'h000, peer_rises});
        rd_reg(ssd_pkg::ADDR_LOWER, r);
        chk_val("lower", {8'h00, pw[7:0]}, {8'h00, r});
        if (nb == 16)
        begin
            rd_reg(ssd_pkg::ADDR_UPPER, r);
            chk_val("upper", {8'h00, pw[15:8]}, {8'h00, r});
        end
        rd_reg(ssd_pkg::ADDR_STAT, r);
        chk_val("status", {9'h001, txd[nb-1], 6'h00}, {8'h00, r});
        chk_bit("so pin", txd[nb-1], so);
        chk_bit("done", 1'b1, done_req);
        chk_bit("irq", done_en, done_irq);
        @(posedge clk_sys_i);
        done_clr <= 1'b1;
        @(posedge clk_sys_i);
        done_clr <= 1'b0;
        @(negedge clk_sys_i);
        chk_bit("done clear", 1'b0, done_req);
    end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        bad_count   = 0;
        comparisons = 0;
        {rst_b_i, reg_wr, reg_rd, done_clr, done_en, peer_load} = 6'h00;
        {reg_addr, reg_wdata, peer_tx, peer_nb, ext_sck} = 32'h00000001;
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_val("status reset", 16'h0080, {8'h00, s});
        rd_reg(ssd_pkg::ADDR_CTRL, s);
        chk_val("control reset", 16'h0000, {8'h00, s});
        wr_reg(ssd_pkg::ADDR_STAT, 8'h7c);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_val("status write", 16'h00c0, {8'h00, s});
        chk_bit("so high", 1'b1, so);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h00);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_val("status low", 16'h0080, {8'h00, s});
        chk_bit("so low", 1'b0, so);
        $display("test registers done");
        for (int i = 0; i < 3; i++)
        begin
            done_en <= i[0];
            run_int(md_tab[i], tx_tab[i], pw_tab[i]);
        end
        $display("test transfers done");
        wr_reg(ssd_pkg::ADDR_CTRL, 8'h00);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h01);
        repeat (700) @(posedge clk_sys_i);
        wr_reg(ssd_pkg::ADDR_CTRL, 8'h00);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_bit("abort go", 1'b0, s[0]);
        chk_bit("abort sck", 1'b1, sck_o);
        wr_reg(ssd_pkg::ADDR_CTRL, 8'h84);
        load_peer(16'h0000, 5'h00);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h01);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_bit("cont go", 1'b0, s[0]);
        repeat (64) @(posedge clk_sys_i);
        chk_bit("cont clock", 1'b1, peer_rises != 5'h00);
        wr_reg(ssd_pkg::ADDR_CTRL, 8'h00);
        $display("test abort done");
        wr_reg(ssd_pkg::ADDR_CTRL, 8'h08);
        wr_reg(ssd_pkg::ADDR_LOWER, 8'h3c);
        load_peer(16'h0096, 5'h08);
        chk_bit("ext oe", 1'b0, sck_oe);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h01);
        ext_pulses(8);
        wait_idle(100);
        chk_val("ext peer rx", 16'h003c, peer_rx >> 8);
        rd_reg(ssd_pkg::ADDR_LOWER, s);
        chk_val("ext lower", 16'h0096, {8'h00, s});
        ext_pulses(1);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_bit("overrun set", 1'b1, s[5]);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h20);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_bit("overrun kept", 1'b1, s[5]);
        wr_reg(ssd_pkg::ADDR_STAT, 8'h00);
        rd_reg(ssd_pkg::ADDR_STAT, s);
        chk_bit("overrun clear", 1'b0, s[5]);
        $display("test external done");
        finish_test();
    end
endmodule // ssd_serial_unit_test
